// >>> maa_core.sv
// Monitor back end: conversion sequencing, averaging, registers and alert pin
//
// Behaviour
// - Current from shunt, zero without calibration
// - Power from latest current and bus sample
// - Arithmetic never lengthens the conversion sequence
// - Averaging above one accumulates, outputs untouched
// - Shunt and bus samples accumulate too
// - After last sample load the averages of the channels the mode converts
// - Five limit checks share one limit value
// - Open-drain alert asserts on limit exceeded
// - Highest set enable bit wins
// - Ready and limit share alert; flags identify
// - Ready alert disabled: alert follows limit only
// - Shunt checks compare after every shunt conversion
// - Limit flag bit 4 set on exceed
// - Alert active level follows polarity bit 1
// - Latched flag clears on config write, mask read
// - Bus checks compare after every bus conversion
// - Power check compares after every bus conversion
// - Conversion times 140 us to 8.244 ms
// - Ready flag set at end, clears on mask read or on config write with mode bits 1:0 nonzero
// - Mode 111 converts shunt then bus forever
// - Current is shunt times calibration over 2048
// - Power LSB is 25 current LSBs
`timescale 1ns/1ps
module maa_core import maa_pkg::*; #(
  parameter int unsigned CONV_CYC [8] = CT_CYC_DEF
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire maa_req_s reg_req_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [15:0] adc_shunt_i,
  input wire logic [15:0] adc_bus_i,
  output logic adc_run_o,
  output logic adc_sel_bus_o,
  output logic alert_o,
  output logic alert_oe_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_SHUNT, ST_BUS} maa_state_e;

  maa_state_e state_r, state_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;
  logic sh_ev_r, sh_ev_nxt, bus_ev_r, bus_ev_nxt;
  logic [15:0] sh_smp_r, sh_smp_nxt, bus_smp_r, bus_smp_nxt;
  logic [15:0] cur_smp_r, cur_smp_nxt, pwr_smp_r, pwr_smp_nxt;
  logic signed [ACC_W-1:0] acc_sh_r, acc_sh_nxt, acc_cur_r, acc_cur_nxt;
  logic [ACC_W-1:0] acc_bus_r, acc_bus_nxt, acc_pwr_r, acc_pwr_nxt;
  logic [15:0] sh_out_r, sh_out_nxt, bus_out_r, bus_out_nxt;
  logic [15:0] cur_out_r, cur_out_nxt, pwr_out_r, pwr_out_nxt;
  logic [CNT_W-1:0] avg_cnt_r, avg_cnt_nxt;
  maa_cfg_s cfg_r, cfg_nxt;
  maa_mask_s mask_r, mask_nxt;
  logic [15:0] cal_r, cal_nxt, limit_r, limit_nxt, rdata_r, rdata_nxt;

  logic cfg_wr, mask_rd, sh_hit, bus_hit, fin, end_ev, last, load_ev;
  logic cmp_ev, cmp_hit, alert_act, pin_high;
  logic [3:0] avg_sh;
  logic [15:0] cur_calc, pwr_calc, cur_mag;
  logic signed [32:0] cur_prod;
  logic [31:0] pwr_prod;

  assign cfg_wr = reg_req_i.wr && reg_req_i.addr == REG_CONFIG;
  assign mask_rd = reg_req_i.rd && reg_req_i.addr == REG_MASK;
  assign avg_sh = AVG_SHIFT[cfg_r.avg];
  assign last = avg_cnt_r == CNT_W'((CNT_W'(1) << avg_sh) - CNT_W'(1));
  assign fin = last && !cfg_r.mode[2];
  assign sh_hit = state_r == ST_SHUNT && tmr_r == TMR_W'(CONV_CYC[cfg_r.sh_ct] - 1);
  assign bus_hit = state_r == ST_BUS && tmr_r == TMR_W'(CONV_CYC[cfg_r.bus_ct] - 1);
  assign end_ev = cfg_r.mode[1] ? bus_ev_r : sh_ev_r;
  assign load_ev = end_ev && last && !cfg_wr;

  // Conversion sequencer
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r + TMR_W'(1);
    sh_ev_nxt = sh_hit;
    bus_ev_nxt = bus_hit;
    sh_smp_nxt = sh_hit ? adc_shunt_i : sh_smp_r;
    bus_smp_nxt = bus_hit ? adc_bus_i : bus_smp_r;
    unique case (state_r)
      ST_IDLE: tmr_nxt = '0;
      ST_SHUNT: begin
        if (sh_hit) begin
          tmr_nxt = '0;
          if (cfg_r.mode[1]) begin
            state_nxt = ST_BUS;
          end else if (fin) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_BUS: begin
        if (bus_hit) begin
          tmr_nxt = '0;
          if (fin) begin
            state_nxt = ST_IDLE;
          end else if (cfg_r.mode[0]) begin
            state_nxt = ST_SHUNT;
          end
        end
      end
    endcase
    if (cfg_wr) begin
      tmr_nxt = '0;
      sh_ev_nxt = 1'b0;
      bus_ev_nxt = 1'b0;
      if (reg_req_i.wdata[0]) begin
        state_nxt = ST_SHUNT;
      end else if (reg_req_i.wdata[1]) begin
        state_nxt = ST_BUS;
      end else begin
        state_nxt = ST_IDLE;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ST_SHUNT;
      tmr_r <= '0;
      sh_ev_r <= 1'b0;
      bus_ev_r <= 1'b0;
      sh_smp_r <= '0;
      bus_smp_r <= '0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      sh_ev_r <= sh_ev_nxt;
      bus_ev_r <= bus_ev_nxt;
      sh_smp_r <= sh_smp_nxt;
      bus_smp_r <= bus_smp_nxt;
    end
  end

  assign adc_run_o = state_r != ST_IDLE;
  assign adc_sel_bus_o = state_r == ST_BUS;

  // Background arithmetic, one cycle after each sample
  assign cur_prod = 33'($signed(sh_smp_r)) * 33'($signed({1'b0, cal_r}));
  assign cur_calc = 16'(cur_prod >>> CAL_SHIFT);
  assign cur_mag = cur_smp_r[15] ? 16'(-cur_smp_r) : cur_smp_r;
  assign pwr_prod = 32'(cur_mag) * 32'(bus_smp_r);
  assign pwr_calc = 16'(pwr_prod / 32'(POWER_DIV));

  always_comb begin
    cur_smp_nxt = sh_ev_r ? cur_calc : cur_smp_r;
    pwr_smp_nxt = bus_ev_r ? pwr_calc : pwr_smp_r;
    acc_sh_nxt = acc_sh_r + (sh_ev_r ? ACC_W'($signed(sh_smp_r)) : '0);
    acc_cur_nxt = acc_cur_r + (sh_ev_r ? ACC_W'($signed(cur_calc)) : '0);
    acc_bus_nxt = acc_bus_r + (bus_ev_r ? ACC_W'(bus_smp_r) : '0);
    acc_pwr_nxt = acc_pwr_r + (bus_ev_r ? ACC_W'(pwr_calc) : '0);
    avg_cnt_nxt = end_ev ? avg_cnt_r + CNT_W'(1) : avg_cnt_r;
    sh_out_nxt = sh_out_r;
    cur_out_nxt = cur_out_r;
    bus_out_nxt = bus_out_r;
    pwr_out_nxt = pwr_out_r;
    if (load_ev) begin
      if (cfg_r.mode[0]) begin
        sh_out_nxt = 16'(acc_sh_nxt >>> avg_sh);
        cur_out_nxt = 16'(acc_cur_nxt >>> avg_sh);
      end
      if (cfg_r.mode[1]) begin
        bus_out_nxt = 16'(acc_bus_nxt >> avg_sh);
        pwr_out_nxt = 16'(acc_pwr_nxt >> avg_sh);
      end
    end
    if (load_ev || cfg_wr) begin
      acc_sh_nxt = '0;
      acc_cur_nxt = '0;
      acc_bus_nxt = '0;
      acc_pwr_nxt = '0;
      avg_cnt_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur_smp_r <= '0;
      pwr_smp_r <= '0;
      acc_sh_r <= '0;
      acc_cur_r <= '0;
      acc_bus_r <= '0;
      acc_pwr_r <= '0;
      avg_cnt_r <= '0;
      sh_out_r <= '0;
      cur_out_r <= '0;
      bus_out_r <= '0;
      pwr_out_r <= '0;
    end else begin
      cur_smp_r <= cur_smp_nxt;
      pwr_smp_r <= pwr_smp_nxt;
      acc_sh_r <= acc_sh_nxt;
      acc_cur_r <= acc_cur_nxt;
      acc_bus_r <= acc_bus_nxt;
      acc_pwr_r <= acc_pwr_nxt;
      avg_cnt_r <= avg_cnt_nxt;
      sh_out_r <= sh_out_nxt;
      cur_out_r <= cur_out_nxt;
      bus_out_r <= bus_out_nxt;
      pwr_out_r <= pwr_out_nxt;
    end
  end

  // Limit comparison on the selected function
  always_comb begin
    cmp_ev = 1'b0;
    cmp_hit = 1'b0;
    unique casez (mask_r.fn)
      5'b1????: begin
        cmp_ev = sh_ev_r;
        cmp_hit = $signed(sh_smp_r) > $signed(limit_r);
      end
      5'b01???: begin
        cmp_ev = sh_ev_r;
        cmp_hit = $signed(sh_smp_r) < $signed(limit_r);
      end
      5'b001??: begin
        cmp_ev = bus_ev_r;
        cmp_hit = bus_smp_r > limit_r;
      end
      5'b0001?: begin
        cmp_ev = bus_ev_r;
        cmp_hit = bus_smp_r < limit_r;
      end
      5'b00001: begin
        cmp_ev = bus_ev_r;
        cmp_hit = pwr_calc > limit_r;
      end
      default: ;
    endcase
  end

  // Registers and flags
  always_comb begin
    cfg_nxt = cfg_r;
    cal_nxt = cal_r;
    limit_nxt = limit_r;
    mask_nxt = mask_r;
    rdata_nxt = rdata_r;
    if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        REG_CONFIG: cfg_nxt = maa_cfg_s'(reg_req_i.wdata);
        REG_CAL: cal_nxt = reg_req_i.wdata;
        REG_LIMIT: limit_nxt = reg_req_i.wdata;
        REG_MASK: begin
          mask_nxt.fn = maa_fn_s'(reg_req_i.wdata[15:11]);
          mask_nxt.ready_alert_enable = reg_req_i.wdata[10];
          mask_nxt.alert_polarity = reg_req_i.wdata[1];
          mask_nxt.latch_enable = reg_req_i.wdata[0];
        end
        default: ;
      endcase
    end
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        REG_CONFIG: rdata_nxt = cfg_r;
        REG_SHUNT: rdata_nxt = sh_out_r;
        REG_BUS: rdata_nxt = bus_out_r;
        REG_POWER: rdata_nxt = pwr_out_r;
        REG_CURRENT: rdata_nxt = cur_out_r;
        REG_CAL: rdata_nxt = cal_r;
        REG_MASK: rdata_nxt = mask_r;
        REG_LIMIT: rdata_nxt = limit_r;
        default: rdata_nxt = '0;
      endcase
    end
    if (mask_r.latch_enable && (cfg_wr || mask_rd)) begin
      mask_nxt.limit_alert_flag = 1'b0;
    end
    if (cmp_ev) begin
      if (cmp_hit) begin
        mask_nxt.limit_alert_flag = 1'b1;
      end else if (!mask_r.latch_enable) begin
        mask_nxt.limit_alert_flag = 1'b0;
      end
    end
    if (mask_rd || (cfg_wr && reg_req_i.wdata[1:0] != 2'b00)) begin
      mask_nxt.conversion_ready_flag = 1'b0;
    end
    if (load_ev) begin
      mask_nxt.conversion_ready_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_r <= maa_cfg_s'(CONFIG_RST);
      cal_r <= CAL_RST;
      limit_r <= LIMIT_RST;
      mask_r <= maa_mask_s'(MASK_RST);
      rdata_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      cal_r <= cal_nxt;
      limit_r <= limit_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  // Open drain: only ever pulls low
  assign alert_act = mask_r.limit_alert_flag
                   || (mask_r.ready_alert_enable && mask_r.conversion_ready_flag);
  assign pin_high = alert_act ? mask_r.alert_polarity : !mask_r.alert_polarity;
  assign alert_o = 1'b0;
  assign alert_oe_o = !pin_high;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  cur_zero_cal_a: assert property (sh_ev_r && cal_r == '0 |=> cur_smp_r == '0)
    else $error("current not zero without calibration");
  pwr_zero_cal_a: assert property (bus_ev_r && cur_smp_r == '0 |=> pwr_smp_r == '0)
    else $error("power not zero with zero current");
  seq_no_gap_a: assert property (sh_hit && cfg_r.mode[1] && !cfg_wr
      |=> state_r == ST_BUS && tmr_r == '0
      ##1 (tmr_r == TMR_W'(1) || $past(cfg_wr)))
    else $error("bus conversion did not follow shunt at once");
  avg_hold_out_a: assert property (end_ev && !last && !cfg_wr
      |=> $stable(cur_out_r) && $stable(pwr_out_r) && $stable(bus_out_r))
    else $error("output changed before averaging ended");
  load_single_a: assert property (load_ev && cfg_r.avg == 3'h0 && cfg_r.mode[1]
      |=> bus_out_r == $past(bus_smp_r))
    else $error("single sample bus result not loaded");
  shunt_over_a: assert property (sh_ev_r && mask_r.fn.shunt_over_limit
      && $signed(sh_smp_r) > $signed(limit_r) |=> mask_r.limit_alert_flag)
    else $error("shunt over limit not flagged");
  latch_clear_a: assert property (mask_r.latch_enable && mask_rd && !cmp_ev
      |=> !mask_r.limit_alert_flag)
    else $error("latched flag not cleared by mask read");
  unlatched_rel_a: assert property (!mask_r.latch_enable && cmp_ev && !cmp_hit
      && !(reg_req_i.wr && reg_req_i.addr == REG_MASK) |=> !mask_r.limit_alert_flag)
    else $error("unlatched flag did not release");
  alert_level_a: assert property (mask_r.limit_alert_flag
      |-> alert_oe_o == !mask_r.alert_polarity)
    else $error("alert level does not follow polarity");
  ready_set_a: assert property (load_ev |=> mask_r.conversion_ready_flag [*1])
    else $error("ready flag not set after load");
  ready_quiet_a: assert property (!mask_r.ready_alert_enable && !mask_r.limit_alert_flag
      |-> alert_oe_o == mask_r.alert_polarity)
    else $error("alert active without limit event");

  load_seen_c: cover property (load_ev ##[1:20] mask_rd);
  alert_both_c: cover property (mask_r.ready_alert_enable && mask_r.limit_alert_flag
      && mask_r.conversion_ready_flag);
  oneshot_idle_c: cover property (state_r != ST_IDLE ##1 state_r == ST_IDLE);

endmodule

// >>> maa_pkg.sv
// Register map, field layouts and timing constants of the monitor back end
package maa_pkg;

  // Register indices on the register port
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_SHUNT = 8'h01;
  localparam logic [7:0] REG_BUS = 8'h02;
  localparam logic [7:0] REG_POWER = 8'h03;
  localparam logic [7:0] REG_CURRENT = 8'h04;
  localparam logic [7:0] REG_CAL = 8'h05;
  localparam logic [7:0] REG_MASK = 8'h06;
  localparam logic [7:0] REG_LIMIT = 8'h07;

  // Values after reset
  localparam logic [15:0] CONFIG_RST = 16'h0127;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] LIMIT_RST = 16'h0000;
  localparam logic [15:0] CAL_RST = 16'h0000;

  // Conversion timing
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned CT_NS [8] = '{140_000, 204_000, 332_000, 588_000,
                                        1_100_000, 2_116_000, 4_156_000, 8_244_000};
  function automatic int unsigned ct_cyc(input int unsigned ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction
  localparam int unsigned CT_CYC_DEF [8] = '{ct_cyc(CT_NS[0]), ct_cyc(CT_NS[1]),
                                             ct_cyc(CT_NS[2]), ct_cyc(CT_NS[3]),
                                             ct_cyc(CT_NS[4]), ct_cyc(CT_NS[5]),
                                             ct_cyc(CT_NS[6]), ct_cyc(CT_NS[7])};
  localparam int TMR_W = 18;

  // Averaging counts 1,4,16,64,128,256,512,1024 as shift amounts
  localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};
  localparam int ACC_W = 26;
  localparam int CNT_W = 11;

  // Arithmetic scaling
  localparam int unsigned CAL_SHIFT = 11;
  localparam int unsigned POWER_LSB_RATIO = 25;
  localparam int unsigned BUS_LSB_UV = 1250;
  localparam int unsigned POWER_DIV = POWER_LSB_RATIO * 1_000_000 / BUS_LSB_UV;

  // Limit function enables, most significant first
  typedef struct packed {
    logic shunt_over_limit;
    logic shunt_under_limit;
    logic bus_over_limit;
    logic bus_under_limit;
    logic power_over_limit;
  } maa_fn_s;

  typedef struct packed {
    logic [3:0] rsv;
    logic [2:0] avg;
    logic [2:0] bus_ct;
    logic [2:0] sh_ct;
    logic [2:0] mode;
  } maa_cfg_s;

  typedef struct packed {
    maa_fn_s fn;
    logic ready_alert_enable;
    logic [4:0] rsv;
    logic limit_alert_flag;
    logic conversion_ready_flag;
    logic rsv2;
    logic alert_polarity;
    logic latch_enable;
  } maa_mask_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } maa_req_s;

endpackage

// >>> maa_adc_model.sv
// Converter front-end model feeding shunt and bus codes to the monitor back end
`timescale 1ns/1ps
module maa_adc_model (
  input wire logic run_i,
  input wire logic sel_bus_i,
  input wire logic [15:0] shunt_val_i,
  input wire logic [15:0] bus_val_i,
  output logic [15:0] shunt_o,
  output logic [15:0] bus_o
);
  // Channel not converting shows inverted code, so a stale sample never passes
  assign shunt_o = (run_i && !sel_bus_i) ? shunt_val_i : ~shunt_val_i;
  assign bus_o = (run_i && sel_bus_i) ? bus_val_i : ~bus_val_i;
endmodule

// >>> tb.sv
// Self-checking testbench for the monitor back end
`timescale 1ns/1ps
module tb import maa_pkg::*;;
  logic sys_clk;
  logic arst_n;
  maa_req_s req;
  logic [15:0] reg_rdata;
  logic [15:0] adc_shunt;
  logic [15:0] adc_bus;
  logic adc_run;
  logic adc_sel_bus;
  logic alert;
  logic alert_oe;
  logic [15:0] sh_val;
  logic [15:0] bus_val;
  logic [15:0] d;
  int n;
  int checked;
  int bad_count;

  // Limit scenarios: enables, limit, shunt, bus, flag, pull-down enable
  localparam logic [15:0] T_MASK [9] = '{16'h8000, 16'h8000, 16'h4000, 16'h2000, 16'h1000,
                                         16'h0800, 16'hc000, 16'h0802, 16'h0802};
  localparam logic [15:0] T_LIM [9] = '{16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0100,
                                        16'h0064, 16'h0100, 16'h0064, 16'hffff};
  localparam logic [15:0] T_SH [9] = '{16'h0200, 16'h0050, 16'h0050, 16'h0200, 16'h0200,
                                       16'h03e8, 16'h0050, 16'h03e8, 16'h03e8};
  localparam logic [15:0] T_BUS [9] = '{16'h0fa0, 16'h0fa0, 16'h0fa0, 16'h0200, 16'h0050,
                                        16'h0fa0, 16'h0fa0, 16'h0fa0, 16'h0fa0};
  localparam logic T_AFF [9] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  localparam logic T_OE [9] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  // Short conversion times for simulation
  localparam int unsigned T_CYC [8] = '{4, 5, 6, 7, 8, 9, 10, 11};

  maa_core #(.CONV_CYC(T_CYC)) i_maa_core (
    .sys_clk_i(sys_clk),
    .arst_n_i(arst_n),
    .reg_req_i(req),
    .reg_rdata_o(reg_rdata),
    .adc_shunt_i(adc_shunt),
    .adc_bus_i(adc_bus),
    .adc_run_o(adc_run),
    .adc_sel_bus_o(adc_sel_bus),
    .alert_o(alert),
    .alert_oe_o(alert_oe)
  );

  maa_adc_model i_maa_adc_model (
    .run_i(adc_run),
    .sel_bus_i(adc_sel_bus),
    .shunt_val_i(sh_val),
    .bus_val_i(bus_val),
    .shunt_o(adc_shunt),
    .bus_o(adc_bus)
  );

  always #25 sys_clk = ~sys_clk;

  task automatic finish_test();
    $display("Counts: checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Pin data must stay low; only the pull-down enable moves
  task automatic chk_pin(input logic exp_oe);
    checked++;
    if ({alert, alert_oe} !== {1'b0, exp_oe}) begin
      bad_count++;
      $display("[FAIL] alert expected %b%b seen %b%b", 1'b0, exp_oe, alert, alert_oe);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge sys_clk);
    req <= '0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [15:0] data);
    @(posedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge sys_clk);
    req <= '0;
    @(negedge sys_clk);
    data = reg_rdata;
  endtask

  task automatic set_adc(input logic [15:0] sh, input logic [15:0] bus);
    @(posedge sys_clk);
    sh_val <= sh;
    bus_val <= bus;
  endtask

  // Count completed bus conversions, then let compare and load settle
  task automatic wait_bus(input int n);
    int seen;
    logic prev;
    seen = 0;
    prev = adc_sel_bus;
    for (int i = 0; i < 400 && seen < n; i++) begin
      @(posedge sys_clk);
      #1;
      if (prev && !adc_sel_bus) seen++;
      prev = adc_sel_bus;
    end
    if (seen < n) begin
      bad_count++;
      $display("[FAIL] bus conversions expected %0d seen %0d", n, seen);
      finish_test();
    end else begin
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
    end
  endtask

  // Count converting cycles of a single-shot run until the sequencer idles
  task automatic wait_idle(output int cyc);
    cyc = 0;
    @(negedge sys_clk);
    for (int i = 0; i < 400 && adc_run; i++) begin
      cyc++;
      @(negedge sys_clk);
    end
    if (adc_run) begin
      bad_count++;
      $display("[FAIL] single shot expected idle seen busy");
      finish_test();
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    req = '0;
    sh_val = 16'h03e8;
    bus_val = 16'h0fa0;
    checked = 0;
    bad_count = 0;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    reg_rd(REG_CONFIG, d);
    chk_reg("config reset", CONFIG_RST, d);
    reg_rd(REG_MASK, d);
    chk_reg("mask reset", MASK_RST, d);
    reg_rd(REG_LIMIT, d);
    chk_reg("limit reset", LIMIT_RST, d);
    reg_rd(8'h08, d);
    chk_reg("unmapped", 16'h0000, d);
    reg_wr(REG_CONFIG, 16'h0007);
    wait_bus(2);
    reg_rd(REG_SHUNT, d);
    chk_reg("shunt", 16'h03e8, d);
    reg_rd(REG_BUS, d);
    chk_reg("bus", 16'h0fa0, d);
    reg_rd(REG_CURRENT, d);
    chk_reg("current uncal", 16'h0000, d);
    reg_rd(REG_POWER, d);
    chk_reg("power uncal", 16'h0000, d);
    reg_wr(REG_CAL, 16'h0800);
    wait_bus(2);
    reg_rd(REG_CAL, d);
    chk_reg("calibration", 16'h0800, d);
    reg_rd(REG_CURRENT, d);
    chk_reg("current", 16'h03e8, d);
    reg_rd(REG_POWER, d);
    chk_reg("power", 16'h00c8, d);
    // Four-sample averaging: outputs hold until the run ends
    set_adc(16'h07d0, 16'h0fa0);
    reg_wr(REG_CONFIG, 16'h0207);
    wait_bus(2);
    reg_rd(REG_SHUNT, d);
    chk_reg("shunt mid run", 16'h03e8, d);
    reg_rd(REG_CURRENT, d);
    chk_reg("current mid run", 16'h03e8, d);
    wait_bus(3);
    reg_rd(REG_SHUNT, d);
    chk_reg("shunt avg", 16'h07d0, d);
    reg_rd(REG_CURRENT, d);
    chk_reg("current avg", 16'h07d0, d);
    reg_rd(REG_POWER, d);
    chk_reg("power avg", 16'h0190, d);
    reg_wr(REG_CONFIG, 16'h0007);
    for (int i = 0; i < 9; i++) begin
      set_adc(T_SH[i], T_BUS[i]);
      reg_wr(REG_LIMIT, T_LIM[i]);
      reg_wr(REG_MASK, T_MASK[i]);
      wait_bus(2);
      chk_pin(T_OE[i]);
      reg_rd(REG_MASK, d);
      chk_reg("limit flag", {15'h0000, T_AFF[i]}, {15'h0000, d[4]});
    end
    // Latched flag survives until mask read, then until config write
    set_adc(16'h0200, 16'h0fa0);
    reg_wr(REG_LIMIT, 16'h0100);
    reg_wr(REG_MASK, 16'h8001);
    wait_bus(2);
    set_adc(16'h0050, 16'h0fa0);
    wait_bus(2);
    chk_pin(1'b1);
    reg_rd(REG_MASK, d);
    chk_reg("latched flag", 16'h0001, {15'h0000, d[4]});
    wait_bus(2);
    chk_pin(1'b0);
    set_adc(16'h0200, 16'h0fa0);
    wait_bus(2);
    set_adc(16'h0050, 16'h0fa0);
    wait_bus(1);
    chk_pin(1'b1);
    reg_wr(REG_CONFIG, 16'h0007);
    wait_bus(2);
    chk_pin(1'b0);
    // Ready flag on the pin; power-down write keeps it, mask read clears it
    reg_wr(REG_MASK, 16'h0400);
    wait_bus(2);
    chk_pin(1'b1);
    reg_wr(REG_CONFIG, 16'h0000);
    repeat (3) @(negedge sys_clk);
    chk_reg("idle", 16'h0000, {15'h0000, adc_run});
    chk_pin(1'b1);
    reg_rd(REG_MASK, d);
    chk_reg("ready flags", 16'h0001, {14'h0000, d[4:3]});
    chk_pin(1'b0);
    // Single shot, shunt only at the longest time code; shunt register refuses writes
    set_adc(16'h0123, 16'h0456);
    reg_wr(REG_CONFIG, 16'h0039);
    wait_idle(n);
    chk_reg("shunt time", 16'(T_CYC[7]), 16'(n));
    reg_wr(REG_SHUNT, 16'h5555);
    reg_rd(REG_SHUNT, d);
    chk_reg("shunt one shot", 16'h0123, d);
    chk_pin(1'b1);
    reg_rd(REG_MASK, d);
    chk_reg("ready one shot", 16'h0001, {15'h0000, d[3]});
    reg_rd(REG_CURRENT, d);
    chk_reg("current one shot", 16'h0123, d);
    // Single shot, bus only: power from the latest current
    reg_wr(REG_CONFIG, 16'h0002);
    wait_idle(n);
    chk_reg("bus time", 16'(T_CYC[0]), 16'(n));
    reg_rd(REG_BUS, d);
    chk_reg("bus one shot", 16'h0456, d);
    reg_rd(REG_POWER, d);
    chk_reg("power one shot", 16'h0010, d);
    finish_test();
  end
endmodule
